/* File: src/uart_interrupt_enable_ident.sv */
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
// Operation
// [R1] bits 7 and 6 enable interrupts on cts or rts low-to-high change
// [R2] bit 5 enables the xoff received interrupt, clear suppresses it
// [R3] bit 4 places the channel in sleep mode
// [R4] bit 3 enables the modem status change interrupt
// [R5] bit 2 enables the receiver line status interrupt
// [R6] bit 1 enables the transmit holding interrupt
// [R7] bit 0 enables the receive data interrupt
// [R8] enable register resets to all zero
// [R9] upper four enable bits writable only while write-enable bit is set
// [R10] re-enabling transmit interrupt alone raises no new interrupt
// [R11] interrupt output active whenever an enabled condition exists
// [R12] identification register is eight bits and read-only
// [R13] identification reports the highest-priority pending source
// [R14] identification bits 7 and 6 mirror the fifo enable bit
// [R15] bit 5 flags handshake rise, bit 4 flags xoff detection
// [R16] bit 0 low while pending, bits 3 to 1 carry source code
// [R17] codes: line status 0110, time-out 1100, receive data 0100
// [R18] priority line, time-out, data, transmit, modem, xoff, handshake
module uart_interrupt_enable_ident (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // apb slave
  input  wire uart_irq_pkg::apb_req_t apb_req,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // uart core conditions, same clock
  input  wire uart_irq_pkg::uart_cond_t cond,
  // modem pin, asynchronous
  input  wire logic                   clear_to_send_line,
  // channel outputs
  output logic                        irq_out_channel,
  output logic                        irq_event,
  output logic                        sleep_mode
);
  import uart_irq_pkg::*;

  // address decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, ADDR_ENABLE) | hit(a, ADDR_IDENT) |
             hit(a, ADDR_CONTROL) | hit(a, ADDR_STATUS) |
             hit(a, ADDR_MASK);
  endfunction : mapped

  logic [7:0]         enable_reg;
  logic [1:0]         control_reg;
  logic [NUM_SRC-1:0] status_reg;
  logic [NUM_SRC-1:0] mask_reg;
  logic               thr_pend_reg;
  logic               xoff_pend_reg;
  logic               hsk_pend_reg;
  logic               tx_below_reg;
  logic               rts_reg;
  logic               cts_meta_reg;
  logic               cts_sync_reg;
  logic               cts_last_reg;
  logic [NUM_SRC-1:0] pend_last_reg;
  logic [NUM_SRC-1:0] ident_src_reg;
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;
  logic               irq_reg;
  logic               irq_event_reg;

  logic               setup;
  logic               access;
  logic               wr_en;
  logic               rd_ident;
  logic               cts_rise;
  logic               rts_rise;
  logic               thr_rise;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] top_src;
  logic [7:0]         ident;

  // bus phases; the access edge is where writes and read effects land
  assign setup    = apb_req.psel & ~apb_req.penable;
  assign access   = apb_req.psel & apb_req.penable & pready_reg;
  assign wr_en    = access & apb_req.pwrite;
  assign rd_ident = access & ~apb_req.pwrite &
                    hit(apb_req.paddr, ADDR_IDENT);

  // two-flop synchroniser, only the second stage is looked at
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cts_meta_reg <= 1'b0;
      cts_sync_reg <= 1'b0;
      cts_last_reg <= 1'b0;
    end else begin
      cts_meta_reg <= clear_to_send_line;
      cts_sync_reg <= cts_meta_reg;
      cts_last_reg <= cts_sync_reg;
    end
  end

  // edge history of the handshake and transmit level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rts_reg      <= 1'b0;
      tx_below_reg <= 1'b0;
    end else begin
      rts_reg      <= cond.rts_level;
      tx_below_reg <= cond.tx_below;
    end
  end

  assign cts_rise = cts_sync_reg & ~cts_last_reg;
  assign rts_rise = cond.rts_level & ~rts_reg;
  assign thr_rise = cond.tx_below & ~tx_below_reg;

  // enable register; upper nibble guarded by the write-enable bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_reg <= ENABLE_RESET; // see [R8]
    end else if (wr_en && hit(apb_req.paddr, ADDR_ENABLE)) begin
      enable_reg[EN_UPPER_LO-1:0] <= apb_req.pwdata[EN_UPPER_LO-1:0];
      if (control_reg[CTL_EFR_WE]) begin
        enable_reg[7:EN_UPPER_LO] <= apb_req.pwdata[7:EN_UPPER_LO]; // see [R9]
      end
    end
  end

  // control bits standing in for the feature and fifo registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control_reg <= CONTROL_RESET;
    end else if (wr_en && hit(apb_req.paddr, ADDR_CONTROL)) begin
      control_reg <= apb_req.pwdata[1:0];
    end
  end

  // sleep mode straight from the enable bit, kept registered
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sleep_mode <= 1'b0;
    end else begin
      sleep_mode <= enable_reg[EN_SLEEP]; // see [R3]
    end
  end

  // transmit pending is edge set, so re-enabling alone cannot fire it;
  // a new crossing of the threshold wins over a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      thr_pend_reg <= 1'b0;
    end else if (thr_rise && enable_reg[EN_THR]) begin
      thr_pend_reg <= 1'b1; // see [R10]
    end else if (cond.tx_write || !enable_reg[EN_THR] ||
                 (rd_ident && ident_src_reg[SRC_THR])) begin
      thr_pend_reg <= 1'b0; // see [R18]
    end
  end

  // xoff detection held until the identification read reports it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xoff_pend_reg <= 1'b0;
    end else if (cond.xoff_seen) begin
      xoff_pend_reg <= 1'b1;
    end else if (rd_ident && ident_src_reg[SRC_XOFF]) begin
      xoff_pend_reg <= 1'b0; // see [R18]
    end
  end

  // handshake rise, each line gated by its own enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hsk_pend_reg <= 1'b0;
    end else if ((cts_rise && enable_reg[EN_CTS]) ||
                 (rts_rise && enable_reg[EN_RTS])) begin
      hsk_pend_reg <= 1'b1; // see [R1]
    end else if (rd_ident && ident_src_reg[SRC_HSK]) begin
      hsk_pend_reg <= 1'b0; // see [R18]
    end
  end

  // enabled pending conditions; level sources clear in the core
  always_comb begin
    pend           = '0;
    pend[SRC_LINE] = cond.line_err & enable_reg[EN_LINE]; // see [R5]
    pend[SRC_TOUT] = cond.rx_timeout & enable_reg[EN_RHR];
    pend[SRC_RHR]  = cond.rx_avail & enable_reg[EN_RHR]; // see [R7]
    pend[SRC_THR]  = thr_pend_reg & enable_reg[EN_THR]; // see [R6]
    pend[SRC_MDM]  = cond.modem_delta & enable_reg[EN_MODEM]; // see [R4]
    pend[SRC_XOFF] = xoff_pend_reg & enable_reg[EN_XOFF]; // see [R2]
    pend[SRC_HSK]  = hsk_pend_reg;
  end

  // fixed priority, lowest index wins
  always_comb begin
    top_src = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        top_src = '0;
        top_src[i] = 1'b1; // see [R13]
      end
    end
  end

  // identification value built from the winning source
  always_comb begin
    ident             = '0;
    ident[3:0]        = CODE_NONE; // see [R16]
    ident[ID_FIFO_HI] = control_reg[CTL_FIFO_EN]; // see [R14]
    ident[ID_FIFO_LO] = control_reg[CTL_FIFO_EN];
    unique case (1'b1)
      top_src[SRC_LINE]: ident[3:0] = CODE_LINE; // see [R17]
      top_src[SRC_TOUT]: ident[3:0] = CODE_TIMEOUT;
      top_src[SRC_RHR]:  ident[3:0] = CODE_RHR;
      top_src[SRC_THR]:  ident[3:0] = CODE_THR;
      top_src[SRC_MDM]:  ident[3:0] = CODE_MODEM;
      top_src[SRC_XOFF]: begin
        ident[3:0]     = CODE_SPECIAL;
        ident[ID_XOFF] = 1'b1; // see [R15]
      end
      top_src[SRC_HSK]:  begin
        ident[3:0]    = CODE_SPECIAL;
        ident[ID_HSK] = 1'b1; // see [R15]
      end
      default:           ident[3:0] = CODE_NONE;
    endcase
  end

  // sticky event bits, set on a new pending edge, write one to clear;
  // a set in the clearing cycle wins so no event is dropped
  generate
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_status
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          status_reg[g] <= 1'b0;
        end else if (pend[g] && !pend_last_reg[g]) begin
          status_reg[g] <= 1'b1;
        end else if (wr_en && hit(apb_req.paddr, ADDR_STATUS) &&
                     apb_req.pwdata[g]) begin
          status_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // pending history for the sticky edge detect
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_last_reg <= SRC_RESET;
    end else begin
      pend_last_reg <= pend;
    end
  end

  // event mask
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_reg <= SRC_RESET;
    end else if (wr_en && hit(apb_req.paddr, ADDR_MASK)) begin
      mask_reg <= apb_req.pwdata[NUM_SRC-1:0];
    end
  end

  // channel interrupt follows any enabled pending condition
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |pend; // see [R11]
    end
  end

  // summary interrupt from the masked sticky bits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_event_reg <= 1'b0;
    end else begin
      irq_event_reg <= |(status_reg & mask_reg);
    end
  end

  // apb answer: ready one cycle after setup, so no wait states;
  // read data and the reported source are frozen at setup
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      prdata_reg    <= '0;
      ident_src_reg <= SRC_RESET;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~mapped(apb_req.paddr);
      if (setup && !apb_req.pwrite) begin
        ident_src_reg <= hit(apb_req.paddr, ADDR_IDENT) ?
                         top_src : SRC_RESET;
        unique case (1'b1)
          hit(apb_req.paddr, ADDR_ENABLE):
            prdata_reg <= {24'h000000, enable_reg};
          hit(apb_req.paddr, ADDR_IDENT):
            prdata_reg <= {24'h000000, ident}; // see [R12]
          hit(apb_req.paddr, ADDR_CONTROL):
            prdata_reg <= {30'h00000000, control_reg};
          hit(apb_req.paddr, ADDR_STATUS):
            prdata_reg <= {25'h0000000, status_reg};
          hit(apb_req.paddr, ADDR_MASK):
            prdata_reg <= {25'h0000000, mask_reg};
          default:
            prdata_reg <= '0;
        endcase
      end else if (setup) begin
        ident_src_reg <= SRC_RESET;
        prdata_reg    <= '0;
      end
    end
  end

  // identification writes fall through every decode above
  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign irq_out_channel = irq_reg;
  assign irq_event       = irq_event_reg;

endmodule : uart_interrupt_enable_ident

/* File: common/uart_irq_pkg.sv */
package uart_irq_pkg;

  // register byte addresses on the apb bus
  localparam logic [7:0] ADDR_ENABLE  = 8'h00;
  localparam logic [7:0] ADDR_IDENT   = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;
  localparam logic [7:0] ADDR_MASK    = 8'h10;

  // interrupt_enable bit positions
  localparam int EN_CTS   = 7;
  localparam int EN_RTS   = 6;
  localparam int EN_XOFF  = 5;
  localparam int EN_SLEEP = 4;
  localparam int EN_MODEM = 3;
  localparam int EN_LINE  = 2;
  localparam int EN_THR   = 1;
  localparam int EN_RHR   = 0;
  localparam int EN_UPPER_LO = 4;
  localparam logic [7:0] ENABLE_RESET = 8'h00;

  // control register bit positions
  localparam int CTL_EFR_WE  = 0;
  localparam int CTL_FIFO_EN = 1;
  localparam logic [1:0] CONTROL_RESET = 2'h0;

  // identification fields
  localparam int ID_FIFO_HI = 7;
  localparam int ID_FIFO_LO = 6;
  localparam int ID_HSK     = 5;
  localparam int ID_XOFF    = 4;
  localparam logic [3:0] CODE_NONE    = 4'h1;
  localparam logic [3:0] CODE_LINE    = 4'h6;
  localparam logic [3:0] CODE_TIMEOUT = 4'hc;
  localparam logic [3:0] CODE_RHR     = 4'h4;
  localparam logic [3:0] CODE_THR     = 4'h2;
  localparam logic [3:0] CODE_MODEM   = 4'h0;
  localparam logic [3:0] CODE_SPECIAL = 4'h0;

  // sticky event status layout, one bit per source
  localparam int NUM_SRC = 7;
  localparam int SRC_LINE = 0;
  localparam int SRC_TOUT = 1;
  localparam int SRC_RHR  = 2;
  localparam int SRC_THR  = 3;
  localparam int SRC_MDM  = 4;
  localparam int SRC_XOFF = 5;
  localparam int SRC_HSK  = 6;
  localparam logic [NUM_SRC-1:0] SRC_RESET = 7'h00;

  // apb request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // condition levels and pulses from the uart core
  typedef struct packed {
    logic line_err;
    logic rx_timeout;
    logic rx_avail;
    logic tx_below;
    logic tx_write;
    logic modem_delta;
    logic xoff_seen;
    logic rts_level;
  } uart_cond_t;

endpackage : uart_irq_pkg

/* File: bench/uart_irq_assertions.sv */
`timescale 1ns/1ps
module uart_irq_assertions
  import uart_irq_pkg::*;
(
  // clock and reset
  input wire logic     sys_clk,
  input wire logic     rst,
  // apb slave
  input wire apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic     pready,
  input wire logic     pslverr,
  // channel outputs
  input wire logic     irq_out_channel,
  input wire logic     irq_event,
  input wire logic     sleep_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // setup phase of one transfer, psel high and penable low
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  // completed enable write; sleep_mode follows it two edges later
  wire logic enable_wr = apb_req.psel && apb_req.penable && pready &&
                         apb_req.pwrite && apb_req.paddr == ADDR_ENABLE;
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (
    s_setup ##0 apb_req.paddr > ADDR_MASK |=> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (
    s_setup ##0 apb_req.paddr == ADDR_ENABLE |=> !pslverr)
    else $error("enable access refused");
  a_ident_width: assert property (
    s_setup ##0 apb_req.paddr == ADDR_IDENT |=> prdata[31:8] == 24'h0)
    else $error("ident wider than a byte");
  // sleep only moves on an enable write, never by itself
  a_sleep_cause: assert property (
    $changed(sleep_mode) |-> $past(enable_wr, 2))
    else $error("sleep changed without write");
  a_reset_quiet: assert property (
    disable iff (1'b0) rst |=> !pready && !irq_out_channel
      && !irq_event && !sleep_mode)
    else $error("outputs active after reset");
endmodule : uart_irq_assertions

bind uart_interrupt_enable_ident uart_irq_assertions i_chk (
  .sys_clk(sys_clk), .rst(rst), .apb_req(apb_req), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq_out_channel(irq_out_channel),
  .irq_event(irq_event), .sleep_mode(sleep_mode)
);

/* File: bench/host_model.sv */
`timescale 1ns/1ps
module host_model
  import uart_irq_pkg::*;
(
  // clock
  input wire logic     sys_clk,
  // slave answer
  input wire logic [31:0] prdata,
  input wire logic     pready,
  input wire logic     pslverr,
  // request
  output apb_req_t     apb_req
);
  initial apb_req = '0;
  // one transfer; waits are bounded so a dead slave cannot hang us
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic err,
    output logic hung);
    int n;
    @(posedge sys_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    hung = 1'b1;
    q = '0;
    err = 1'b0;
    for (n = 0; n < 16 && hung; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) begin
        hung = 1'b0;
        q = prdata;
        err = pslverr;
      end
    end
    apb_req <= '0;
  endtask : xfer
endmodule : host_model

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import uart_irq_pkg::*;
  logic sys_clk, rst, pready, pslverr, cts, irq, irq_ev, sleep;
  logic [31:0] prdata, q;
  logic        e, h;
  apb_req_t    req;
  uart_cond_t  cond;
  int fails = 0;
  int checks_done = 0;

  uart_interrupt_enable_ident i_dut (.sys_clk(sys_clk), .rst(rst),
    .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cond(cond), .clear_to_send_line(cts), .irq_out_channel(irq),
    .irq_event(irq_ev), .sleep_mode(sleep));
  host_model i_host (.sys_clk(sys_clk), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .apb_req(req));

  // free running system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic ok);
    checks_done++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t mismatch", $time);
    end
  endtask : chk

  task automatic go(input logic w, input logic [7:0] a, input logic [7:0] d);
    i_host.xfer(w, a, {24'h0, d}, q, e, h);
    if (h === 1'b1) begin
      fails++;
      summarize();
    end
  endtask : go

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    go(1'b1, a, d);
  endtask : wr

  // read compares the low byte and the error flag together
  task automatic rd(input logic [7:0] a, input logic [7:0] x,
    input logic xe = 1'b0);
    go(1'b0, a, 8'h0);
    chk(q[7:0] === x && e === xe);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : settle

  task automatic t_enable;
    rd(ADDR_ENABLE, 8'h00);
    rd(ADDR_IDENT, 8'h01);
    wr(ADDR_ENABLE, 8'hff);
    rd(ADDR_ENABLE, 8'h0f);
    wr(ADDR_CONTROL, 8'h01);
    wr(ADDR_ENABLE, 8'h10);
    rd(ADDR_ENABLE, 8'h10);
    chk(sleep === 1'b1);
    wr(ADDR_ENABLE, 8'h07);
    settle(2);
    chk(sleep === 1'b0);
    $display("enable test done");
  endtask : t_enable

  task automatic t_prio;
    cond.line_err <= 1'b1;
    cond.rx_timeout <= 1'b1;
    cond.rx_avail <= 1'b1;
    settle(3);
    chk(irq === 1'b1);
    rd(ADDR_IDENT, 8'h06);
    cond.line_err <= 1'b0;
    rd(ADDR_IDENT, 8'h0c);
    cond.rx_timeout <= 1'b0;
    rd(ADDR_IDENT, 8'h04);
    rd(ADDR_STATUS, 8'h07);
    chk(irq_ev === 1'b0);
    wr(ADDR_MASK, 8'h04);
    settle(2);
    chk(irq_ev === 1'b1);
    cond.rx_avail <= 1'b0;
    wr(ADDR_STATUS, 8'h07);
    rd(ADDR_STATUS, 8'h00);
    chk(irq_ev === 1'b0 && irq === 1'b0);
    $display("priority test done");
  endtask : t_prio

  task automatic t_thr;
    wr(ADDR_ENABLE, 8'h00);
    cond.tx_below <= 1'b1;
    wr(ADDR_ENABLE, 8'h02);
    settle(3);
    chk(irq === 1'b0);
    cond.tx_below <= 1'b0;
    settle(2);
    cond.tx_below <= 1'b1;
    settle(3);
    chk(irq === 1'b1);
    rd(ADDR_IDENT, 8'h02);
    rd(ADDR_IDENT, 8'h01);
    cond.tx_below <= 1'b0;
    $display("transmit test done");
  endtask : t_thr

  task automatic t_events;
    wr(ADDR_ENABLE, 8'h20);
    cond.xoff_seen <= 1'b1;
    @(posedge sys_clk);
    cond.xoff_seen <= 1'b0;
    settle(3);
    rd(ADDR_IDENT, 8'h10);
    rd(ADDR_IDENT, 8'h01);
    wr(ADDR_ENABLE, 8'h40);
    cond.rts_level <= 1'b1;
    settle(3);
    rd(ADDR_IDENT, 8'h20);
    wr(ADDR_ENABLE, 8'h80);
    cts <= 1'b1;
    settle(6);
    rd(ADDR_IDENT, 8'h20);
    wr(ADDR_ENABLE, 8'h08);
    cond.modem_delta <= 1'b1;
    settle(3);
    rd(ADDR_IDENT, 8'h00);
    cond.modem_delta <= 1'b0;
    rd(ADDR_IDENT, 8'h01);
    $display("event test done");
  endtask : t_events

  task automatic t_misc;
    wr(ADDR_CONTROL, 8'h03);
    rd(ADDR_IDENT, 8'hc1);
    wr(ADDR_IDENT, 8'h3e);
    rd(ADDR_IDENT, 8'hc1);
    rd(8'h20, 8'h00, 1'b1);
    $display("misc test done");
  endtask : t_misc

  // main sequence, reset held three cycles
  initial begin
    rst = 1'b1;
    cond = '0;
    cts = 1'b0;
    settle(3);
    rst <= 1'b0;
    t_enable();
    t_prio();
    t_thr();
    t_events();
    t_misc();
    summarize();
  end
endmodule : tb_top
